/* include/xfer_pkg.sv */
// Shared constants, types and helpers of the data transfer request port
package xfer_pkg;
  localparam int SLOTS = 8;
  localparam int SLOT_W = 3;
  localparam int ADDR_W = 64;
  localparam int LUN_W = 64;
  localparam int TAG_W = 16;
  localparam int OFS_W = 32;
  localparam int LEN_W = 32;
  localparam int RA_W = 8;
  localparam int RD_W = 32;

  typedef enum logic [1:0] {CMD_NONE, CMD_READ, CMD_WRITE, CMD_BIDI} cmd_e;

  localparam logic FRAME_DATA = 1'b0;
  localparam logic FRAME_XRDY = 1'b1;

  localparam logic [RA_W-1:0] REG_CTRL = 8'h00;
  localparam logic [RA_W-1:0] REG_STATUS = 8'h04;
  localparam logic [RA_W-1:0] REG_MASK = 8'h08;
  localparam logic [RA_W-1:0] REG_FRAMES = 8'h0C;
  localparam logic [RA_W-1:0] REG_REJECT = 8'h10;
  localparam logic [RD_W-1:0] CTRL_RESET = 32'h0000_0001;
  localparam int CTRL_EN_BIT = 0;

  localparam int EV_W = 4;
  localparam int ST_DATA_OK = 0;
  localparam int ST_DATA_FAIL = 1;
  localparam int ST_OUT_DONE = 2;
  localparam int ST_REJECT = 3;

  localparam logic [2:0] REJ_NONE = 3'h0;
  localparam logic [2:0] REJ_DISABLED = 3'h1;
  localparam logic [2:0] REJ_NO_CMD = 3'h2;
  localparam logic [2:0] REJ_DIRECTION = 3'h3;
  localparam logic [2:0] REJ_CLOSED = 3'h4;
  localparam logic [2:0] REJ_BUSY = 3'h5;

  localparam int CLK_PERIOD_NS = 25;
  localparam int ACK_TIMEOUT_NS = 1000;
  // Longest wait, so the division rounds down
  localparam logic [15:0] ACK_TIMEOUT_CYC =
    16'(ACK_TIMEOUT_NS / CLK_PERIOD_NS);

  // Legality of a transfer request against the state of its nexus slot
  function automatic logic [2:0] check_req(input logic en,
                                           input cmd_e cmd,
                                           input logic closed,
                                           input logic busy,
                                           input logic want_write);
    logic wrong_dir;
    wrong_dir = want_write ? (cmd == CMD_READ) : (cmd == CMD_WRITE);
    if (!en)
      return REJ_DISABLED;
    else if (cmd == CMD_NONE)
      return REJ_NO_CMD;
    else if (wrong_dir)
      return REJ_DIRECTION;
    else if (closed)
      return REJ_CLOSED;
    else if (want_write && busy)
      return REJ_BUSY;
    else
      return REJ_NONE;
  endfunction
endpackage

/* src/ack_timer.sv */
// Wait counter that ends a data frame's wait for an acknowledgement
`timescale 1ns/100ps
module ack_timer
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  output logic expired
);
  import xfer_pkg::*;

  logic [15:0] cnt;
  wire logic at_end = (cnt == ACK_TIMEOUT_CYC - 16'h0001);

  assign expired = run && at_end;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt <= 16'h0000;
    else if (!run)
      cnt <= 16'h0000;
    else if (!at_end)
      cnt <= cnt + 16'h0001;
  end

  // Cycles since the wait began; unlike cnt it does not stop at the end
  logic [15:0] waited;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      waited <= 16'h0000;
    else if (!run)
      waited <= 16'h0000;
    else if (waited != 16'hFFFF)
      waited <= waited + 16'h0001;
  end

  // Fires once per wait, only at its last cycle, and never misses it
  expiry_time_a: // RQ7
    assert property (@(posedge clk) disable iff (!nrst)
      expired |-> waited == ACK_TIMEOUT_CYC - 16'h0001)
    else $error("ack wait expired at the wrong cycle");
  expiry_late_a: // RQ7
    assert property (@(posedge clk) disable iff (!nrst)
      run && waited == ACK_TIMEOUT_CYC - 16'h0001 |-> expired)
    else $error("ack wait did not expire on time");
endmodule

/* src/ssp_xfer_port.sv */
// Target port data transfer requests: read data and transfer-ready frames
//
// How it works
// [RQ1] Read data only during read or bidirectional command
// [RQ2] No read data after completion or abort
// [RQ3] Frame goes to requested initiator, LUN, tag
// [RQ4] Requested offset becomes data offset field
// [RQ5] Payload length equals requested byte count
// [RQ6] Delivery indication carries frame header nexus
// [RQ7] ACK gives success; NAK or silence, failure
// [RQ8] Write request sends one transfer-ready frame
// [RQ9] Transfer-ready only during write or bidirectional
// [RQ10] Next transfer-ready waits for previous success
// [RQ11] No transfer-ready after completion or abort
// [RQ12] Transfer-ready addressed with requested nexus fields
// [RQ13] Requested offset becomes requested offset field
// [RQ14] Byte count becomes write data length field
// [RQ15] Report write data outcome with nexus, result
// [RQ16] Track nexus state; refuse illegal requests
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module ssp_xfer_port
#(
  // Own port address; value is arbitrary
  parameter logic [63:0] TARGET_ADDR = 64'h0000_0000_0000_0001
)
(
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic [xfer_pkg::RA_W-1:0] ADDR,
  input wire logic [xfer_pkg::RD_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [xfer_pkg::RD_W-1:0] RDATA,
  output logic IRQ,
  input wire logic CMD_OPEN,
  input wire logic CMD_CLOSE,
  input wire logic [xfer_pkg::SLOT_W-1:0] CMD_SLOT,
  input wire xfer_pkg::cmd_e CMD_TYPE,
  input wire logic DIN_REQ,
  input wire logic DOUT_REQ,
  input wire logic [xfer_pkg::SLOT_W-1:0] REQ_SLOT,
  input wire logic [xfer_pkg::ADDR_W-1:0] REQ_INIT,
  input wire logic [xfer_pkg::LUN_W-1:0] REQ_LUN,
  input wire logic [xfer_pkg::TAG_W-1:0] REQ_TAG,
  input wire logic [xfer_pkg::OFS_W-1:0] REQ_OFFSET,
  input wire logic [xfer_pkg::LEN_W-1:0] REQ_COUNT,
  output logic REQ_READY,
  output logic REQ_REJECT,
  output logic FRM_VALID,
  input wire logic FRM_READY,
  output logic FRM_KIND,
  output logic [xfer_pkg::ADDR_W-1:0] FRM_INIT,
  output logic [xfer_pkg::LUN_W-1:0] FRM_LUN,
  output logic [xfer_pkg::TAG_W-1:0] FRM_TAG,
  output logic [xfer_pkg::OFS_W-1:0] FRM_OFFSET,
  output logic [xfer_pkg::LEN_W-1:0] FRM_LEN,
  input wire logic LINK_ACK,
  input wire logic LINK_NAK,
  input wire logic OUT_DONE,
  input wire logic [xfer_pkg::SLOT_W-1:0] OUT_SLOT,
  input wire logic OUT_OK,
  output logic IND_VALID,
  output logic IND_KIND,
  output logic [xfer_pkg::ADDR_W-1:0] IND_INIT,
  output logic [xfer_pkg::ADDR_W-1:0] IND_TGT,
  output logic [xfer_pkg::LUN_W-1:0] IND_LUN,
  output logic [xfer_pkg::TAG_W-1:0] IND_TAG,
  output logic IND_OK
);
  import xfer_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_SEND, S_WAIT} st_e;

  st_e state;
  st_e next_state;
  logic enable;
  logic ack_expired;
  logic out_pend;
  logic [SLOT_W-1:0] out_slot_q;
  logic out_ok_q;
  logic [RD_W-1:0] frames;
  logic [2:0] last_reason;

  cmd_e slot_cmd [SLOTS];
  logic slot_closed [SLOTS];
  logic slot_busy [SLOTS];
  logic [ADDR_W-1:0] slot_init [SLOTS];
  logic [LUN_W-1:0] slot_lun [SLOTS];
  logic [TAG_W-1:0] slot_tag [SLOTS];

  ////////////////////////////////////////////////////////////////////////////
  // Request decode and legality

  // Both strobes at once: the read data request is served
  wire logic req_any = DIN_REQ || DOUT_REQ;
  wire logic req_write = DOUT_REQ && !DIN_REQ;
  wire logic take = req_any && REQ_READY;
  wire logic [2:0] din_reason = check_req(enable, slot_cmd[REQ_SLOT],
    slot_closed[REQ_SLOT], slot_busy[REQ_SLOT], 1'b0); // RQ1 RQ2
  wire logic [2:0] dout_reason = check_req(enable, slot_cmd[REQ_SLOT],
    slot_closed[REQ_SLOT], slot_busy[REQ_SLOT], 1'b1); // RQ9 RQ10 RQ11
  wire logic [2:0] reason = req_write ? dout_reason : din_reason;
  wire logic accept = take && (reason == REJ_NONE);
  wire logic reject = take && (reason != REJ_NONE); // RQ16
  wire logic waiting = (state == S_WAIT);
  // ACK seen with a NAK in the same cycle counts as delivered
  wire logic link_ok = waiting && LINK_ACK; // RQ7
  wire logic link_fail = waiting && !LINK_ACK
    && (LINK_NAK || ack_expired); // RQ7
  wire logic frame_gone = (state == S_SEND) && FRM_READY;
  // A pending write outcome is reported before new work is taken
  wire logic out_emit = (state == S_IDLE) && out_pend; // RQ15
  wire logic next_out_pend = OUT_DONE || (out_pend && !out_emit);
  wire logic [EV_W-1:0] events = {reject, out_emit, link_fail, link_ok};

  assign REQ_READY = (state == S_IDLE) && !out_pend;
  assign FRM_VALID = (state == S_SEND);

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer

  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE:
        if (accept)
          next_state = S_SEND;
      S_SEND:
        if (FRM_READY)
          next_state = (FRM_KIND == FRAME_DATA) ? S_WAIT : S_IDLE;
      S_WAIT:
        if (link_ok || link_fail)
          next_state = S_IDLE;
      default:
        next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  // Header fields are copied straight from the request
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      FRM_KIND <= FRAME_DATA;
      FRM_INIT <= '0;
      FRM_LUN <= '0;
      FRM_TAG <= '0;
      FRM_OFFSET <= '0;
      FRM_LEN <= '0;
    end
    else if (accept)
    begin
      FRM_KIND <= req_write ? FRAME_XRDY : FRAME_DATA; // RQ8
      FRM_INIT <= REQ_INIT; // RQ3 RQ12
      FRM_LUN <= REQ_LUN; // RQ3 RQ12
      FRM_TAG <= REQ_TAG; // RQ3 RQ12
      FRM_OFFSET <= REQ_OFFSET; // RQ4 RQ13
      FRM_LEN <= REQ_COUNT; // RQ5 RQ14
    end
  end

  ack_timer u_timer
  (
    .clk(CLOCK),
    .nrst(NRST),
    .run(waiting),
    .expired(ack_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Nexus slot table

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      for (int i = 0; i < SLOTS; i++)
      begin
        slot_cmd[i] <= CMD_NONE;
        slot_closed[i] <= 1'b0;
        slot_busy[i] <= 1'b0;
      end
    end
    else
    begin
      if (CMD_OPEN)
      begin
        slot_cmd[CMD_SLOT] <= CMD_TYPE;
        slot_closed[CMD_SLOT] <= 1'b0;
        slot_busy[CMD_SLOT] <= 1'b0;
      end
      if (CMD_CLOSE)
        slot_closed[CMD_SLOT] <= 1'b1; // RQ16
      // A failed write transfer keeps the slot busy until reopened
      if (OUT_DONE && OUT_OK)
        slot_busy[OUT_SLOT] <= 1'b0; // RQ10
      if (accept && req_write)
        slot_busy[REQ_SLOT] <= 1'b1; // RQ10
    end
  end

  // Nexus of the outstanding transfer-ready, for its outcome report
  always_ff @(posedge CLOCK)
  begin
    if (accept && req_write)
    begin
      slot_init[REQ_SLOT] <= REQ_INIT;
      slot_lun[REQ_SLOT] <= REQ_LUN;
      slot_tag[REQ_SLOT] <= REQ_TAG;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indications to the device server

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      out_pend <= 1'b0;
      out_slot_q <= '0;
      out_ok_q <= 1'b0;
    end
    else
    begin
      out_pend <= next_out_pend;
      if (OUT_DONE)
      begin
        out_slot_q <= OUT_SLOT;
        out_ok_q <= OUT_OK;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      IND_VALID <= 1'b0;
      IND_KIND <= FRAME_DATA;
      IND_INIT <= '0;
      IND_TGT <= '0;
      IND_LUN <= '0;
      IND_TAG <= '0;
      IND_OK <= 1'b0;
    end
    else
    begin
      IND_VALID <= link_ok || link_fail || out_emit;
      if (link_ok || link_fail)
      begin
        IND_KIND <= FRAME_DATA;
        IND_INIT <= FRM_INIT; // RQ6
        IND_TGT <= TARGET_ADDR; // RQ6
        IND_LUN <= FRM_LUN; // RQ6
        IND_TAG <= FRM_TAG; // RQ6
        IND_OK <= link_ok; // RQ7
      end
      else if (out_emit)
      begin
        IND_KIND <= FRAME_XRDY;
        IND_INIT <= slot_init[out_slot_q]; // RQ15
        IND_TGT <= TARGET_ADDR; // RQ15
        IND_LUN <= slot_lun[out_slot_q]; // RQ15
        IND_TAG <= slot_tag[out_slot_q]; // RQ15
        IND_OK <= out_ok_q; // RQ15
      end
    end
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      REQ_REJECT <= 1'b0;
      last_reason <= REJ_NONE;
      frames <= '0;
    end
    else
    begin
      REQ_REJECT <= reject; // RQ16
      if (reject)
        last_reason <= reason;
      if (frame_gone)
        frames <= frames + 32'h0000_0001;
    end
  end

  xfer_regs u_regs
  (
    .clk(CLOCK),
    .nrst(NRST),
    .addr(ADDR),
    .wdata(WDATA),
    .wr(WR),
    .rd(RD),
    .rdata(RDATA),
    .events(events),
    .frames(frames),
    .reason(last_reason),
    .enable(enable),
    .irq(IRQ)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);

  hdr_nexus_a: // RQ3
    assert property (accept && !req_write |=> FRM_VALID
      && FRM_INIT == $past(REQ_INIT) && FRM_LUN == $past(REQ_LUN)
      && FRM_TAG == $past(REQ_TAG))
    else $error("read data header differs from request");
  data_offset_a: // RQ4
    assert property (accept && !req_write |=>
      FRM_OFFSET == $past(REQ_OFFSET) && FRM_KIND == FRAME_DATA)
    else $error("data offset differs from request");
  data_len_a: // RQ5
    assert property (accept && !req_write |=>
      (FRM_LEN == $past(REQ_COUNT)) throughout (FRM_VALID [*1]))
    else $error("payload size differs from byte count");
  ind_nexus_a: // RQ6
    assert property (IND_VALID && IND_KIND == FRAME_DATA |->
      IND_TAG == FRM_TAG && IND_LUN == FRM_LUN && IND_TGT == TARGET_ADDR)
    else $error("delivery indication nexus wrong");
  ack_ok_a: // RQ7
    assert property (link_ok |=> IND_VALID && IND_OK && state == S_IDLE)
    else $error("acknowledged frame not reported as delivered");
  nak_fail_a: // RQ7
    assert property (waiting && LINK_NAK && !LINK_ACK |=>
      IND_VALID && !IND_OK)
    else $error("negative acknowledgement not reported as failure");
  xrdy_send_a: // RQ8
    assert property (accept && req_write |=> FRM_VALID
      && FRM_KIND == FRAME_XRDY)
    else $error("write request did not start a transfer-ready frame");
  xrdy_once_a: // RQ8
    assert property (frame_gone && FRM_KIND == FRAME_XRDY |=> !FRM_VALID)
    else $error("transfer-ready frame offered more than once");
  xrdy_fields_a: // RQ12 RQ13 RQ14
    assert property (accept && req_write |=> FRM_INIT == $past(REQ_INIT)
      && FRM_OFFSET == $past(REQ_OFFSET) && FRM_LEN == $past(REQ_COUNT))
    else $error("transfer-ready fields differ from request");
  xrdy_wait_a: // RQ10
    assert property (take && req_write && slot_busy[REQ_SLOT] |=>
      REQ_REJECT && !FRM_VALID)
    else $error("second transfer-ready accepted while one outstanding");
  out_report_a: // RQ15
    assert property ($rose(out_pend) |-> ##[0:60] (IND_VALID
      && IND_KIND == FRAME_XRDY))
    else $error("write data outcome not reported in time");
  refuse_a: // RQ16
    assert property (reject |=> REQ_REJECT && state == S_IDLE
      && last_reason != REJ_NONE)
    else $error("illegal request not refused");

  data_ok_c: cover property (accept && !req_write ##[1:20] link_ok);
  data_timeout_c: cover property (waiting && ack_expired);
  xrdy_report_c: cover property (accept && req_write ##[1:80] out_emit);
  reject_c: cover property (reject && reason == REJ_CLOSED);
endmodule

/* src/xfer_regs.sv */
// Register slave: control, sticky status, mask, frame counter and interrupt
`timescale 1ns/100ps
module xfer_regs
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [xfer_pkg::RA_W-1:0] addr,
  input wire logic [xfer_pkg::RD_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [xfer_pkg::RD_W-1:0] rdata,
  input wire logic [xfer_pkg::EV_W-1:0] events,
  input wire logic [xfer_pkg::RD_W-1:0] frames,
  input wire logic [2:0] reason,
  output logic enable,
  output logic irq
);
  import xfer_pkg::*;

  logic [RD_W-1:0] ctrl;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;

  wire logic status_rd = rd && (addr == REG_STATUS);
  // Set wins over the read clear, so no event is lost
  wire logic [EV_W-1:0] next_status = (status & ~{EV_W{status_rd}}) | events;
  wire logic [RD_W-1:0] read_mux =
    (addr == REG_CTRL) ? ctrl :
    (addr == REG_STATUS) ? {{(RD_W-EV_W){1'b0}}, status} :
    (addr == REG_MASK) ? {{(RD_W-EV_W){1'b0}}, mask} :
    (addr == REG_FRAMES) ? frames :
    (addr == REG_REJECT) ? {{(RD_W-3){1'b0}}, reason} : '0;

  assign enable = ctrl[CTRL_EN_BIT];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl <= CTRL_RESET;
      mask <= '0;
      status <= '0;
      rdata <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr && addr == REG_CTRL)
        ctrl <= wdata;
      if (wr && addr == REG_MASK)
        mask <= wdata[EV_W-1:0];
      status <= next_status;
      rdata <= rd ? read_mux : '0;
      irq <= |(next_status & mask);
    end
  end
endmodule

/* tb/link_model.sv */
// Link side model: frame acceptance, ACK or NAK replies, write outcome
`timescale 1ns/100ps
module link_model
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic frm_valid,
  input wire logic frm_kind,
  input wire logic [1:0] mode,
  input wire logic [3:0] stall,
  input wire logic ok,
  input wire logic [2:0] slot,
  output logic frm_ready,
  output logic link_ack,
  output logic link_nak,
  output logic out_done,
  output logic [2:0] out_slot,
  output logic out_ok
);
  logic [3:0] wait_cnt;
  logic [2:0] resp_cnt;
  logic resp_kind;
  logic fire;

  assign fire = (resp_cnt == 3'h1);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      frm_ready <= 1'b0;
      wait_cnt <= 4'h0;
      resp_cnt <= 3'h0;
      resp_kind <= 1'b0;
    end
    else
    begin
      frm_ready <= 1'b0;
      if (frm_valid && !frm_ready)
      begin
        frm_ready <= (wait_cnt == stall);
        wait_cnt <= (wait_cnt == stall) ? 4'h0 : wait_cnt + 4'h1;
      end
      if (frm_valid && frm_ready)
      begin
        resp_cnt <= 3'h3;
        resp_kind <= frm_kind;
      end
      else if (resp_cnt != 3'h0)
        resp_cnt <= resp_cnt - 3'h1;
    end
  end

  // Mode 2 stays silent so the port has to give up on its own
  assign link_ack = fire && !resp_kind && (mode == 2'h0);
  assign link_nak = fire && !resp_kind && (mode == 2'h1);
  assign out_done = fire && resp_kind;
  // Outside the pulse the outcome lines show junk, not the last value
  assign out_slot = out_done ? slot : ~slot;
  assign out_ok = out_done ? ok : ~ok;
endmodule

/* tb/ssp_target_data_xfer_requests_tb_top.sv */
// Self-checking bench of the transfer request port with a link model
`timescale 1ns/100ps
module ssp_target_data_xfer_requests_tb_top;
  import xfer_pkg::*;

  // Own port address; value is arbitrary
  localparam logic [63:0] TGT = 64'h0000_0000_0000_0042;

  typedef struct packed {
    logic wr;
    logic [2:0] slot;
    cmd_e cmd;
    logic open;
    logic [1:0] mode;
    logic ok;
    logic [2:0] rej;
  } row_s;

  logic CLOCK, NRST, WR, RD, IRQ, CMD_OPEN, CMD_CLOSE, m_ok;
  logic DIN_REQ, DOUT_REQ, REQ_READY, REQ_REJECT, FRM_VALID, FRM_READY;
  logic FRM_KIND, LINK_ACK, LINK_NAK, OUT_DONE, OUT_OK;
  logic IND_VALID, IND_KIND, IND_OK;
  logic [RA_W-1:0] ADDR;
  logic [RD_W-1:0] WDATA, RDATA;
  logic [SLOT_W-1:0] CMD_SLOT, REQ_SLOT, OUT_SLOT, m_slot;
  cmd_e CMD_TYPE;
  logic [ADDR_W-1:0] REQ_INIT, FRM_INIT, IND_INIT, IND_TGT;
  logic [LUN_W-1:0] REQ_LUN, FRM_LUN, IND_LUN;
  logic [TAG_W-1:0] REQ_TAG, FRM_TAG, IND_TAG;
  logic [OFS_W-1:0] REQ_OFFSET, FRM_OFFSET;
  logic [LEN_W-1:0] REQ_COUNT, FRM_LEN;
  logic [1:0] m_mode;
  logic [3:0] m_stall;
  int err_total = 0;
  int cmp_count = 0;
  int k = 0;

  row_s rows [8] = '{
    '{1'b0, 3'h0, CMD_READ, 1'b1, 2'h0, 1'b1, REJ_NONE},
    '{1'b0, 3'h1, CMD_BIDI, 1'b1, 2'h1, 1'b0, REJ_NONE},
    '{1'b0, 3'h2, CMD_READ, 1'b1, 2'h2, 1'b0, REJ_NONE},
    '{1'b1, 3'h3, CMD_WRITE, 1'b1, 2'h0, 1'b1, REJ_NONE},
    '{1'b1, 3'h4, CMD_BIDI, 1'b1, 2'h0, 1'b0, REJ_NONE},
    '{1'b0, 3'h5, CMD_WRITE, 1'b1, 2'h0, 1'b0, REJ_DIRECTION},
    '{1'b1, 3'h6, CMD_READ, 1'b1, 2'h0, 1'b0, REJ_DIRECTION},
    '{1'b1, 3'h3, CMD_WRITE, 1'b0, 2'h0, 1'b1, REJ_NONE}
  };

  ssp_xfer_port #(.TARGET_ADDR(TGT)) DUT (.*);

  link_model far_end
  (
    .clk(CLOCK), .nrst(NRST), .frm_valid(FRM_VALID), .frm_kind(FRM_KIND),
    .mode(m_mode), .stall(m_stall), .ok(m_ok), .slot(m_slot),
    .frm_ready(FRM_READY), .link_ack(LINK_ACK), .link_nak(LINK_NAK),
    .out_done(OUT_DONE), .out_slot(OUT_SLOT), .out_ok(OUT_OK)
  );

  always #12.5 CLOCK = ~CLOCK;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic reg_wr(input logic [RA_W-1:0] a, input logic [RD_W-1:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
    @(posedge CLOCK);
  endtask

  task automatic reg_rd(input string nm, input logic [RA_W-1:0] a,
                        input logic [RD_W-1:0] e);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    @(negedge CLOCK);
    chk(nm, RDATA, e);
    @(posedge CLOCK);
  endtask

  task automatic irq_chk(input logic e);
    repeat (2) @(posedge CLOCK);
    @(negedge CLOCK);
    chk("irq", IRQ, e);
    @(posedge CLOCK);
  endtask

  task automatic cmd_pulse(input logic open, input logic [2:0] s,
                           input cmd_e t);
    CMD_OPEN <= open;
    CMD_CLOSE <= !open;
    CMD_SLOT <= s;
    CMD_TYPE <= t;
    @(posedge CLOCK);
    CMD_OPEN <= 1'b0;
    CMD_CLOSE <= 1'b0;
    @(posedge CLOCK);
  endtask

  // Device server side: one request, then its frame and indication, or its refusal and reject reason
  task automatic run_row(input row_s r);
    int n;
    n = 0;
    k++;
    if (r.open)
      cmd_pulse(1'b1, r.slot, r.cmd);
    m_mode <= r.mode;
    m_ok <= r.ok;
    m_slot <= r.slot;
    m_stall <= 4'(k % 4);
    DIN_REQ <= !r.wr;
    DOUT_REQ <= r.wr;
    REQ_SLOT <= r.slot;
    REQ_INIT <= 64'h0123_4567_89AB_0000 + 64'(k);
    REQ_LUN <= 64'h0000_0001_0000_0000 << k;
    REQ_TAG <= 16'h0A00 + 16'(k);
    REQ_OFFSET <= 32'h0000_1000 + 32'(k);
    REQ_COUNT <= 32'h0000_0200 + 32'(k);
    @(negedge CLOCK);
    while (REQ_READY !== 1'b1 && n < 200)
    begin
      @(negedge CLOCK);
      n++;
    end
    chk("req ready", REQ_READY, 1'b1);
    @(posedge CLOCK);
    DIN_REQ <= 1'b0;
    DOUT_REQ <= 1'b0;
    @(negedge CLOCK);
    chk("reject", REQ_REJECT, r.rej != REJ_NONE);
    chk("frm valid", FRM_VALID, r.rej == REJ_NONE);
    if (r.rej != REJ_NONE)
    begin
      @(posedge CLOCK);
      reg_rd("reason", REG_REJECT, 32'(r.rej));
    end
    else
    begin
      chk("frm kind", FRM_KIND, r.wr);
      chk("frm init", FRM_INIT, REQ_INIT);
      chk("frm lun", FRM_LUN, REQ_LUN);
      chk("frm tag", FRM_TAG, REQ_TAG);
      chk("frm offset", FRM_OFFSET, REQ_OFFSET);
      chk("frm len", FRM_LEN, REQ_COUNT);
      chk("req busy", REQ_READY, 1'b0);
      n = 0;
      while (IND_VALID !== 1'b1 && n < 200)
      begin
        @(negedge CLOCK);
        n++;
      end
      chk("ind valid", IND_VALID, 1'b1);
      chk("ind kind", IND_KIND, r.wr);
      chk("ind init", IND_INIT, REQ_INIT);
      chk("ind tgt", IND_TGT, TGT);
      chk("ind lun", IND_LUN, REQ_LUN);
      chk("ind tag", IND_TAG, REQ_TAG);
      chk("ind ok", IND_OK, r.ok);
      chk("req free", REQ_READY, 1'b1);
    end
    @(posedge CLOCK);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge CLOCK);
    err_total++;
    wrap_up();
  end

  initial
  begin
    {CLOCK, NRST, WR, RD, CMD_OPEN, CMD_CLOSE, DIN_REQ, DOUT_REQ} = '0;
    {ADDR, WDATA, CMD_SLOT, REQ_SLOT, REQ_INIT, REQ_LUN} = '0;
    {REQ_TAG, REQ_OFFSET, REQ_COUNT, m_mode, m_stall, m_ok, m_slot} = '0;
    CMD_TYPE = CMD_NONE;
    repeat (12) @(posedge CLOCK);
    NRST <= 1'b1;
    @(posedge CLOCK);
    foreach (rows[i])
      run_row(rows[i]);
    irq_chk(1'b0);
    reg_rd("frames", REG_FRAMES, 32'h0000_0006);
    reg_rd("status", REG_STATUS, 32'h0000_000F);
    reg_rd("status clr", REG_STATUS, 32'h0000_0000);
    run_row('{1'b1, 3'h4, CMD_BIDI, 1'b0, 2'h0, 1'b0, REJ_BUSY});
    reg_wr(REG_MASK, 32'h0000_0008);
    irq_chk(1'b1);
    reg_rd("status rej", REG_STATUS, 32'h0000_0008);
    irq_chk(1'b0);
    cmd_pulse(1'b0, 3'h0, CMD_READ);
    run_row('{1'b0, 3'h0, CMD_READ, 1'b0, 2'h0, 1'b0, REJ_CLOSED});
    cmd_pulse(1'b0, 3'h3, CMD_WRITE);
    run_row('{1'b1, 3'h3, CMD_WRITE, 1'b0, 2'h0, 1'b0, REJ_CLOSED});
    reg_wr(REG_CTRL, 32'h0000_0000);
    run_row('{1'b0, 3'h1, CMD_BIDI, 1'b0, 2'h0, 1'b0, REJ_DISABLED});
    reg_wr(REG_CTRL, CTRL_RESET);
    // Second reset in mid-run empties the slot table
    NRST <= 1'b0;
    repeat (2) @(posedge CLOCK);
    NRST <= 1'b1;
    @(posedge CLOCK);
    reg_wr(8'h14, 32'hFFFF_FFFF);
    reg_rd("ctrl", REG_CTRL, 32'h0000_0001);
    reg_rd("mask", REG_MASK, 32'h0000_0000);
    reg_rd("frames rst", REG_FRAMES, 32'h0000_0000);
    reg_rd("unmapped", 8'h14, 32'h0000_0000);
    run_row('{1'b0, 3'h1, CMD_BIDI, 1'b0, 2'h0, 1'b0, REJ_NO_CMD});
    wrap_up();
  end
endmodule
